//--- hdl/dcf_pkg.sv
package dcf_pkg;

	// word and threshold widths
	localparam int DATA_W      = 18;
	localparam int THR_W       = 12;
	// default depth of the main array and of the write staging buffer
	localparam int DEPTH_DEF   = 256;
	localparam int STAGE_DEPTH = 8;
	// depths for which the default threshold changes
	localparam int DEPTH_SMALL = 256;
	localparam int DEPTH_MID   = 512;
	// default thresholds by depth
	localparam logic [THR_W-1:0] THR_DEF_SMALL = 12'h01f;
	localparam logic [THR_W-1:0] THR_DEF_MID   = 12'h03f;
	localparam logic [THR_W-1:0] THR_DEF_LARGE = 12'h07f;
	// read data after reset
	localparam logic [DATA_W-1:0] READ_DATA_RST = 18'h00000;

	// which threshold the load sequence points at
	typedef enum logic
	{
		DCF_SEL_EMPTY,
		DCF_SEL_FULL
	} dcf_thr_sel_t;

	// status flags, all active low
	typedef struct packed
	{
		logic empty_flag_n;
		logic near_empty_flag_n;
		logic half_level_flag_n;
		logic near_full_flag_n;
		logic full_flag_n;
	} dcf_flags_t;

	// empty buffer: empty and near-empty asserted, the rest released
	localparam dcf_flags_t FLAGS_RST = '{
		empty_flag_n:      1'b0,
		near_empty_flag_n: 1'b0,
		half_level_flag_n: 1'b1,
		near_full_flag_n:  1'b1,
		full_flag_n:       1'b1
	};

	// threshold used until software loads one
	function automatic logic [THR_W-1:0] thr_default(input int depth);
		logic [THR_W-1:0] t;
		t = THR_DEF_LARGE;
		if (depth <= DEPTH_SMALL)
			t = THR_DEF_SMALL;
		else if (depth <= DEPTH_MID)
			t = THR_DEF_MID;
		return t;
	endfunction

endpackage

//--- hdl/dcf_stage_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module dcf_stage_fifo #(
	parameter int W = 18,
	parameter int N = 8
)(
	input  wire logic                 clk,       // system clock
	input  wire logic                 rstn,      // sync reset, active low
	input  wire logic                 ce,        // clock enable
	input  wire logic                 in_valid,  // word offered
	output logic                      in_ready,  // room for a word
	input  wire logic [W-1:0]         in_data,   // word in
	output logic                      out_valid, // word available
	input  wire logic                 out_ready, // drain accepts
	output logic [W-1:0]              out_data,  // oldest word
	output logic [$clog2(N):0]        level      // words held
);
	localparam int AW = $clog2(N);

	typedef struct packed
	{
		logic [N-1:0][W-1:0] mem;
		logic [AW:0]         wp;
		logic [AW:0]         rp;
	} dcf_stage_st_t;

	dcf_stage_st_t s;
	dcf_stage_st_t next_s;

	// full and empty come from the pointer distance, never guessed
	assign level     = s.wp - s.rp;
	assign in_ready  = level != (AW+1)'(N);
	assign out_valid = level != '0;
	assign out_data  = s.mem[s.rp[AW-1:0]];

	// push and pop may both happen in one cycle
	always_comb
	begin
		next_s = s;
		if (in_valid && in_ready)
		begin
			next_s.mem[s.wp[AW-1:0]] = in_data;
			next_s.wp = s.wp + 1'b1;
		end
		if (out_valid && out_ready)
			next_s.rp = s.rp + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

endmodule
`default_nettype wire

//--- hdl/dcf_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo #(
	parameter int DEPTH = dcf_pkg::DEPTH_DEF,
	parameter int STAGE = dcf_pkg::STAGE_DEPTH
)(
	input  wire logic                        ref_clk,          // system clock
	input  wire logic                        rstn,             // master reset
	input  wire logic                        ce,               // freezes all
	input  wire logic                        write_clk,        // write strobe
	input  wire logic                        write_en_n,       // write enable
	input  wire logic [dcf_pkg::DATA_W-1:0]  write_data,       // input word
	input  wire logic                        read_clk,         // read strobe
	input  wire logic                        read_en_n,        // read enable
	input  wire logic                        output_enable_n,  // drive q
	input  wire logic                        threshold_load_n, // thr access
	input  wire logic                        replay_strobe,    // rewind read
	input  wire logic                        flag_sync_select, // 1: async nf
	output logic [dcf_pkg::DATA_W-1:0]       read_data,        // output word
	output logic                             read_data_oe,     // q driven
	output dcf_pkg::dcf_flags_t              flags             // status
);
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam int LW = $clog2(STAGE) + 1;
	localparam int HALF = DEPTH / 2;
	localparam logic [dcf_pkg::THR_W-1:0] THR_RST =
		dcf_pkg::thr_default(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][dcf_pkg::DATA_W-1:0] mem;
		logic [PW-1:0]                         wbin;
		logic [PW-1:0]                         wg;
		logic [PW-1:0]                         rbin;
		logic [PW-1:0]                         rg;
		logic [PW-1:0]                         wg_s1;
		logic [PW-1:0]                         wg_s2;
		logic [PW-1:0]                         rg_s1;
		logic [PW-1:0]                         rg_s2;
		logic                                  wclk_q;
		logic                                  rclk_q;
		dcf_pkg::dcf_thr_sel_t                 sel;
		logic [dcf_pkg::THR_W-1:0]             near_empty_distance;
		logic [dcf_pkg::THR_W-1:0]             near_full_distance;
		logic [dcf_pkg::DATA_W-1:0]            q;
		logic                                  q_oe;
		dcf_pkg::dcf_flags_t                   fl;
	} dcf_st_t;

	dcf_st_t s;
	dcf_st_t next_s;

	// pointer coding for the crossing
	function automatic logic [PW-1:0] b2g(input logic [PW-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b[PW-1] = g[PW-1];
		for (int i = PW - 2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	logic                        w_edge;
	logic                        r_edge;
	logic                        w_acc;
	logic                        r_acc;
	logic                        lw;
	logic                        lr;
	logic                        stg_ready;
	logic                        stg_valid;
	logic                        arr_room;
	logic [dcf_pkg::DATA_W-1:0]  stg_data;
	logic [LW-1:0]               stg_level;
	logic [PW-1:0]               rsync;
	logic [PW-1:0]               wsync;
	logic [PW-1:0]               arr_w;
	logic [PW-1:0]               wcnt;
	logic [PW-1:0]               rcnt;
	logic [dcf_pkg::DATA_W-1:0]  rd_word;
	logic                        nf_now;
	logic                        ne_now;

	// strobe pins are sampled levels, so a rising edge is found here
	assign w_edge = write_clk && !s.wclk_q;
	assign r_edge = read_clk && !s.rclk_q;
	// only the second stage of each synchroniser is decoded
	assign rsync = g2b(s.rg_s2);
	assign wsync = g2b(s.wg_s2);
	// stale flags are conservative: full may linger, empty may linger
	assign w_acc = w_edge && !write_en_n && threshold_load_n
		&& s.fl.full_flag_n && stg_ready;
	assign r_acc = r_edge && !read_en_n && threshold_load_n
		&& s.fl.empty_flag_n;
	assign lw = w_edge && !write_en_n && !threshold_load_n;
	assign lr = r_edge && !read_en_n && !threshold_load_n;
	assign arr_w = s.wbin - rsync;
	assign arr_room = arr_w != PW'(DEPTH);
	assign rd_word = s.mem[s.rbin[AW-1:0]];

	// staged words already count as stored for the write-side flags
	dcf_stage_fifo #(
		.W (dcf_pkg::DATA_W),
		.N (STAGE)
	) u_stage (
		.clk       (ref_clk),
		.rstn      (rstn),
		.ce        (ce),
		.in_valid  (w_acc),
		.in_ready  (stg_ready),
		.in_data   (write_data),
		.out_valid (stg_valid),
		.out_ready (arr_room),
		.out_data  (stg_data),
		.level     (stg_level)
	);

	// whole next state; flags are computed from post-update counts
	always_comb
	begin
		next_s = s;
		next_s.wclk_q = write_clk;
		next_s.rclk_q = read_clk;
		next_s.wg_s1 = s.wg;
		next_s.wg_s2 = s.wg_s1;
		next_s.rg_s1 = s.rg;
		next_s.rg_s2 = s.rg_s1;
		next_s.q_oe = !output_enable_n;
		// drain the staging buffer into the array
		if (stg_valid && arr_room)
		begin
			next_s.mem[s.wbin[AW-1:0]] = stg_data;
			next_s.wbin = s.wbin + 1'b1;
		end
		// threshold load; one step per cycle even if both sides hit
		if (lw)
		begin
			unique case (s.sel)
				dcf_pkg::DCF_SEL_EMPTY:
					next_s.near_empty_distance =
						write_data[dcf_pkg::THR_W-1:0];
				dcf_pkg::DCF_SEL_FULL:
					next_s.near_full_distance =
						write_data[dcf_pkg::THR_W-1:0];
			endcase
		end
		if (lr)
		begin
			unique case (s.sel)
				dcf_pkg::DCF_SEL_EMPTY:
					next_s.q = {{(dcf_pkg::DATA_W-dcf_pkg::THR_W){1'b0}},
						s.near_empty_distance};
				dcf_pkg::DCF_SEL_FULL:
					next_s.q = {{(dcf_pkg::DATA_W-dcf_pkg::THR_W){1'b0}},
						s.near_full_distance};
			endcase
		end
		// the sequence is reset only by rstn, so a later load picks up after it
		if (lw || lr)
		begin
			unique case (s.sel)
				dcf_pkg::DCF_SEL_EMPTY:
					next_s.sel = dcf_pkg::DCF_SEL_FULL;
				dcf_pkg::DCF_SEL_FULL:
					next_s.sel = dcf_pkg::DCF_SEL_EMPTY;
			endcase
		end
		// normal read; an empty buffer keeps q untouched
		if (r_acc)
		begin
			next_s.q = rd_word;
			next_s.rbin = s.rbin + 1'b1;
		end
		// rewind wins over a read in the same cycle
		if (replay_strobe)
			next_s.rbin = '0;
		next_s.wg = b2g(next_s.wbin);
		next_s.rg = b2g(next_s.rbin);
		// write-side count includes what waits in staging
		wcnt = arr_w + PW'(stg_level) + PW'(w_acc);
		rcnt = wsync - next_s.rbin;
		nf_now = int'(wcnt) >= DEPTH - int'(s.near_full_distance);
		ne_now = int'(rcnt) <= int'(s.near_empty_distance);
		if (w_edge)
			next_s.fl.full_flag_n = wcnt != PW'(DEPTH);
		if (r_edge)
			next_s.fl.empty_flag_n = rcnt != '0;
		if (w_edge || flag_sync_select)
			next_s.fl.near_full_flag_n = !nf_now;
		if (r_edge || flag_sync_select)
			next_s.fl.near_empty_flag_n = !ne_now;
		next_s.fl.half_level_flag_n = !(int'(wcnt) > HALF);
	end

	// reset empties both pointers and restores default thresholds
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			s <= '0;
			s.q <= dcf_pkg::READ_DATA_RST;
			s.near_empty_distance <= THR_RST;
			s.near_full_distance <= THR_RST;
			s.sel <= dcf_pkg::DCF_SEL_EMPTY;
			s.fl <= dcf_pkg::FLAGS_RST;
		end
		else if (ce)
			s <= next_s;
	end

	assign read_data = s.q;
	assign read_data_oe = s.q_oe;
	assign flags = s.fl;

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_load_empty;
		ce && lw && s.sel == dcf_pkg::DCF_SEL_EMPTY;
	endsequence

	sequence s_empty_loaded;
		s.near_empty_distance == $past(write_data[dcf_pkg::THR_W-1:0])
			&& s.sel == dcf_pkg::DCF_SEL_FULL;
	endsequence

	property p_load_seq;
		s_load_empty |=> s_empty_loaded;
	endproperty
	a_load_seq: assert property (p_load_seq)
		else $error("load write did not hit empty threshold then advance");

	property p_read_word;
		ce && r_acc && !replay_strobe |=> read_data == $past(rd_word)
			&& s.rbin == $past(s.rbin) + 1'b1;
	endproperty
	a_read_word: assert property (p_read_word)
		else $error("read did not present the addressed word");

	property p_empty_hold;
		ce && !flags.empty_flag_n && !lr |=> $stable(read_data);
	endproperty
	a_empty_hold: assert property (p_empty_hold)
		else $error("read data changed while empty");

	property p_oe;
		ce ##1 ce |-> read_data_oe == !$past(output_enable_n);
	endproperty
	a_oe: assert property (p_oe)
		else $error("output drive does not follow output enable");

	property p_full_block;
		!flags.full_flag_n |-> !w_acc;
	endproperty
	a_full_block: assert property (p_full_block)
		else $error("write taken while full");

	property p_full_sync;
		!w_edge |=> $stable(flags.full_flag_n);
	endproperty
	a_full_sync: assert property (p_full_sync)
		else $error("full flag moved without a write edge");

	property p_empty_sync;
		!r_edge |=> $stable(flags.empty_flag_n);
	endproperty
	a_empty_sync: assert property (p_empty_sync)
		else $error("empty flag moved without a read edge");

	property p_near_full_sync;
		!flag_sync_select && !w_edge |=> $stable(flags.near_full_flag_n);
	endproperty
	a_near_full_sync: assert property (p_near_full_sync)
		else $error("near-full flag moved without a write edge");

	property p_near_empty_sync;
		!flag_sync_select && !r_edge |=> $stable(flags.near_empty_flag_n);
	endproperty
	a_near_empty_sync: assert property (p_near_empty_sync)
		else $error("near-empty flag moved without a read edge");

	// a load read of the full threshold shows it and steps back to empty
	sequence s_load_read_full;
		ce && lr && s.sel == dcf_pkg::DCF_SEL_FULL;
	endsequence

	sequence s_full_shown;
		read_data[dcf_pkg::THR_W-1:0] == $past(s.near_full_distance)
			&& s.sel == dcf_pkg::DCF_SEL_EMPTY;
	endsequence

	property p_thr_read;
		s_load_read_full |=> s_full_shown;
	endproperty
	a_thr_read: assert property (p_thr_read)
		else $error("load read did not show the full threshold");

	property p_empty_block;
		ce && !flags.empty_flag_n && !replay_strobe |=> $stable(s.rbin);
	endproperty
	a_empty_block: assert property (p_empty_block)
		else $error("read pointer moved while empty");

	property p_replay;
		ce && replay_strobe |=> s.rbin == '0 ##2 s.rg_s2 == '0 || ce == 0;
	endproperty
	a_replay: assert property (p_replay)
		else $error("replay did not rewind the read pointer");

	property p_reset;
		!rstn |=> !flags.empty_flag_n && read_data == '0 && s.wbin == '0;
	endproperty
	a_reset: assert property (disable iff (1'b0) p_reset)
		else $error("reset did not empty the buffer");

endmodule
`default_nettype wire

//--- dv/dcf_port_partner.sv
`timescale 1ns/100ps
`default_nettype none
// producer and consumer logic on the two strobe ports
module dcf_port_partner (
	input  wire logic                   ref_clk,         // system clock
	output logic                        write_clk,       // write strobe
	output logic                        write_en_n,      // write enable
	output logic [dcf_pkg::DATA_W-1:0]  write_data,      // word offered
	output logic                        read_clk,        // read strobe
	output logic                        read_en_n,       // read enable
	output logic                        threshold_load_n // threshold access
);
	// strobes start low so the release of reset sees no edge
	initial
	begin
		write_clk = 1'b0;
		write_en_n = 1'b1;
		write_data = '0;
		read_clk = 1'b0;
		read_en_n = 1'b1;
		threshold_load_n = 1'b1;
	end

	// one write edge; released data shows the inverse so no stale match
	task automatic put(input logic [dcf_pkg::DATA_W-1:0] d, input logic ld);
		@(posedge ref_clk) #1;
		write_clk = 1'b1;
		write_en_n = 1'b0;
		write_data = d;
		threshold_load_n = ld;
		@(posedge ref_clk) #1;
		write_clk = 1'b0;
		write_en_n = 1'b1;
		write_data = ~d;
		threshold_load_n = 1'b1;
	endtask

	// one read edge; the strobe is low again before the next call
	task automatic get(input logic en_n, input logic ld);
		@(posedge ref_clk) #1;
		read_clk = 1'b1;
		read_en_n = en_n;
		threshold_load_n = ld;
		@(posedge ref_clk) #1;
		read_clk = 1'b0;
		read_en_n = 1'b1;
		threshold_load_n = 1'b1;
	endtask
endmodule
`default_nettype wire

//--- dv/test_dcf_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module test_dcf_fifo;
	localparam int DEPTH = 16;
	logic                        ref_clk;
	logic                        rstn;
	logic                        ce;
	logic                        output_enable_n;
	logic                        replay_strobe;
	logic                        flag_sync_select;
	wire logic                   write_clk;
	wire logic                   write_en_n;
	wire logic [17:0]            write_data;
	wire logic                   read_clk;
	wire logic                   read_en_n;
	wire logic                   threshold_load_n;
	logic [17:0]                 read_data;
	logic                        read_data_oe;
	dcf_pkg::dcf_flags_t         flags;
	int                          fail_count = 0;
	int                          check_count = 0;
	int                          cycles = 0;

	dcf_port_partner p (.ref_clk(ref_clk), .write_clk(write_clk),
		.write_en_n(write_en_n), .write_data(write_data),
		.read_clk(read_clk), .read_en_n(read_en_n),
		.threshold_load_n(threshold_load_n));

	// small depth keeps fill and drain short
	dcf_fifo #(.DEPTH(DEPTH), .STAGE(dcf_pkg::STAGE_DEPTH)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .write_clk(write_clk),
		.write_en_n(write_en_n), .write_data(write_data),
		.read_clk(read_clk), .read_en_n(read_en_n),
		.output_enable_n(output_enable_n),
		.threshold_load_n(threshold_load_n),
		.replay_strobe(replay_strobe),
		.flag_sync_select(flag_sync_select), .read_data(read_data),
		.read_data_oe(read_data_oe), .flags(flags));

	initial
		ref_clk = 1'b0;
	always #2.5 ref_clk = ~ref_clk;

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard, far above the 200 or so cycles the run needs
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [17:0] got, input logic [17:0] exp,
		input string m);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// strobes stay idle for the whole reset
	task automatic do_reset();
		rstn = 1'b0;
		repeat (8) @(posedge ref_clk);
		#1 rstn = 1'b1;
		@(posedge ref_clk) #1;
	endtask

	function automatic logic [17:0] word(input int i);
		return 18'h2a000 + 18'(i);
	endfunction

	// empty threshold 2, full threshold 3; upper data bits must be dropped
	task automatic program_thr();
		p.put(18'h3f002, 1'b0);
		p.put(18'h3f003, 1'b0);
	endtask

	initial
	begin
		rstn = 1'b0;
		ce = 1'b1;
		output_enable_n = 1'b0;
		replay_strobe = 1'b0;
		flag_sync_select = 1'b0;
		do_reset();
		chk(read_data, 18'h00000, "data after reset");
		chk({13'h0, flags}, {13'h0, dcf_pkg::FLAGS_RST}, "reset flags");
		chk({17'h0, read_data_oe}, 18'h00001, "drive on");
		// defaults read back through the shared load pointer
		repeat (2)
		begin
			p.get(1'b0, 1'b0);
			chk(read_data, {6'h00, dcf_pkg::THR_DEF_SMALL}, "default");
		end
		program_thr();
		p.get(1'b0, 1'b0);
		chk(read_data, 18'h00002, "empty thr");
		p.get(1'b0, 1'b0);
		chk(read_data, 18'h00003, "full thr");
		// fill to the top, then one write that must be dropped
		for (int i = 0; i < DEPTH; i++)
			p.put(word(i), 1'b1);
		chk({15'h0, flags.half_level_flag_n, flags.near_full_flag_n,
			flags.full_flag_n}, 18'h00000, "full flags");
		p.put(18'h3ffff, 1'b1);
		output_enable_n = 1'b1;
		@(posedge ref_clk) #1;
		chk({17'h0, read_data_oe}, 18'h00000, "drive off");
		output_enable_n = 1'b0;
		// empty flag moves only on a read edge, so strobe once disabled
		repeat (6) @(posedge ref_clk);
		p.get(1'b1, 1'b1);
		chk({17'h0, flags.empty_flag_n}, 18'h00001, "not empty");
		for (int i = 0; i < DEPTH; i++)
		begin
			p.get(1'b0, 1'b1);
			chk(read_data, word(i), "drain");
		end
		chk({17'h0, flags.empty_flag_n}, 18'h00000, "empty");
		p.get(1'b0, 1'b1);
		chk(read_data, word(DEPTH - 1), "hold last");
		// both ports idle around the replay pulse
		replay_strobe = 1'b1;
		@(posedge ref_clk) #1;
		replay_strobe = 1'b0;
		repeat (4) @(posedge ref_clk);
		p.get(1'b1, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			p.get(1'b0, 1'b1);
			chk(read_data, word(i), "replay");
		end
		// second reset mid-run, near flags follow every cycle from here
		do_reset();
		flag_sync_select = 1'b1;
		program_thr();
		for (int i = 0; i < 8; i++)
			p.put(word(i + 32), 1'b1);
		repeat (6) @(posedge ref_clk);
		chk({15'h0, flags.near_empty_flag_n, flags.half_level_flag_n,
			flags.near_full_flag_n}, 18'h00007, "eight words");
		for (int i = 8; i < 13; i++)
			p.put(word(i + 32), 1'b1);
		repeat (6) @(posedge ref_clk);
		chk({16'h0, flags.half_level_flag_n, flags.near_full_flag_n},
			18'h00000, "thirteen words");
		p.get(1'b1, 1'b1);
		for (int i = 0; i < 11; i++)
			p.get(1'b0, 1'b1);
		chk(read_data, word(42), "partial drain");
		// a strobe that comes and goes while frozen must be missed
		ce = 1'b0;
		p.get(1'b0, 1'b1);
		ce = 1'b1;
		chk(read_data, word(42), "frozen read");
		repeat (6) @(posedge ref_clk);
		chk({17'h0, flags.near_empty_flag_n}, 18'h00000, "two words");
		tally_and_finish();
	end
endmodule
`default_nettype wire
